// ===== inc/acs_pkg.sv
// package: register map, field layout, timing counts and states of the conversion sequencer
`default_nettype none
package acs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL0 = 12'h000;
  localparam logic [11:0] OFF_CTRL1 = 12'h004;
  localparam logic [11:0] OFF_DATA_H = 12'h008;
  localparam logic [11:0] OFF_DATA_L = 12'h00c;
  localparam logic [11:0] OFF_PWR = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h014;
  localparam logic [11:0] OFF_CAL_BASE = 12'h400;
  // control register 0 fields
  localparam int unsigned C0_SEL_LSB = 0;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned C0_CONTINUOUS_MODE_SELECT = 4;
  localparam int unsigned C0_REFOUT = 5;
  localparam int unsigned C0_REFL = 6;
  localparam int unsigned C0_START = 7;
  // control/status register 1 and power control fields
  localparam int unsigned C1_REFH = 7;
  localparam int unsigned PWR_ADC_DIS = 2;
  // status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_POWERED = 1;
  localparam int unsigned ST_CONTINUOUS_MODE_SELECT_RUN = 2;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic CTRL1_REFH_RST = 1'b0;
  localparam logic PWR_ADC_DIS_RST = 1'b0;
  // result layout
  localparam int unsigned RES_W = 11;
  localparam int unsigned RES_HI_W = 8;
  localparam int unsigned RES_LO_W = RES_W - RES_HI_W;
  localparam int unsigned RES_LO_LSB = 5;
  // timing counts in system clock cycles
  localparam int unsigned TMR_W = 13;
  localparam int unsigned CYC_FIRST = 5129;
  localparam logic [TMR_W-1:0] CYC_POWERUP = 13'h0028;
  localparam logic [TMR_W-1:0] CYC_REPEAT = 13'h0100;
  localparam logic [7:0] CYC_IDLE_OFF = 8'ha0;
  // calibration bytes: offset, gain high, gain low per reference type
  localparam int unsigned CAL_NUM = 9;
  localparam logic [7:0] CAL_INFO_ADDR [CAL_NUM] = '{
    8'h60, 8'h08, 8'h09,
    8'h63, 8'h0a, 8'h0b,
    8'h66, 8'h0c, 8'h0d
  };
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PWRUP = 4'b0010,
    S_FIRST = 4'b0100,
    S_CONTINUOUS_MODE_SELECT = 4'b1000
  } acs_state_t;
endpackage
`default_nettype wire

// ===== hw/acs_seq_timer.sv
// cycle down-counter that pulses done in the last cycle of a loaded interval
`default_nettype none
module acs_seq_timer #(
  parameter int unsigned W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic clear,
  output logic done,
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (clear)
      cnt_q <= '0;
    else if (load)
      cnt_q <= load_val;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  // loaded with n, done is high n cycles later
  assign done = (cnt_q == W'(1));
  assign count = cnt_q;
endmodule
`default_nettype wire

// ===== hw/acs_top.sv
// conversion sequencer: axi4-lite registers, conversion timing, results and pin control
// What this block does
// - on single completion store 11-bit result in upper and lower bytes, clear start
// - power converter down after 160 consecutive idle cycles
// - continuous mode keeps converting; each result overwrites the data registers
// - continuous-mode bit written 1 selects continuous, 0 single conversion
// - four-bit input-select field chooses the analog source to convert
// - reference-output bit routes internal reference to a pin; reference must be on
// - reference pair: high bit in register 1, low bit in register 0
// - every field of control register 0 except start is written by one write; start can only be set
// - writing 1 to start launches a conversion or the continuous sequence
// - first conversion done 5129 cycles after start, 40 more when powering up
// - in continuous mode start clears at first result and stays clear
// - interrupt request at first completion and after every later one
// - after the first continuous result, a new result every 256 cycles
// - clearing the continuous-mode bit stops further conversions
// - interrupt only for a completion while the converter is enabled
// - disabling the converter never clears an already pending request
// - analog function on a pin disables its digital input and output driver
// - nine calibration bytes: offset and two gain bytes per reference type
// - calibration bytes sit at fixed information page locations
// - converter-disable bit 1 powers converter off, 0 enables it
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module acs_top #(
  parameter int unsigned FIRST_CYC = acs_pkg::CYC_FIRST,
  parameter int unsigned N_PINS = 4,
  parameter logic [8*acs_pkg::CAL_NUM-1:0] CAL_BYTES = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [acs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [acs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [acs_pkg::RES_W-1:0] adc_result,
  output logic adc_power_on,
  output logic adc_converting,
  output logic [acs_pkg::SEL_W-1:0] analog_input_select,
  output logic [1:0] reference_select,
  output logic reference_output_enable,
  output logic irq_req,
  input wire logic [N_PINS-1:0] gpio_analog_sel,
  input wire logic [N_PINS-1:0] gpio_oe_req,
  output logic [N_PINS-1:0] gpio_oe,
  output logic [N_PINS-1:0] gpio_ie
);
  localparam logic [acs_pkg::TMR_W-1:0] FIRST_LD = acs_pkg::TMR_W'(FIRST_CYC);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // {found, byte} for a calibration word address
  function automatic logic [8:0] cal_read(input logic [11:0] a);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < acs_pkg::CAL_NUM; i++)
    begin
      if (hit(a, acs_pkg::OFF_CAL_BASE + {2'b00, acs_pkg::CAL_INFO_ADDR[i], 2'b00}))
        r = {1'b1, CAL_BYTES[8*i +: 8]};
    end
    cal_read = r;
  endfunction

  // ==========================================================
  // register bus: write channels
  logic aw_have_q;
  logic [11:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_wr;
  logic wr_ok;
  logic wr_c0;
  logic wr_c1;
  logic wr_pwr;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok = hit(aw_addr_q, acs_pkg::OFF_CTRL0) || hit(aw_addr_q, acs_pkg::OFF_CTRL1)
    || hit(aw_addr_q, acs_pkg::OFF_PWR);
  // registers are one byte wide: only lane 0 carries data
  assign wr_c0 = do_wr && w_strb_q[0] && hit(aw_addr_q, acs_pkg::OFF_CTRL0);
  assign wr_c1 = do_wr && w_strb_q[0] && hit(aw_addr_q, acs_pkg::OFF_CTRL1);
  assign wr_pwr = do_wr && w_strb_q[0] && hit(aw_addr_q, acs_pkg::OFF_PWR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_wr)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (do_wr)
      w_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= acs_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // control registers
  logic [acs_pkg::SEL_W-1:0] sel_q;
  logic continuous_mode_select_q;
  logic refout_q;
  logic refl_q;
  logic refh_q;
  logic start_q;
  logic adc_dis_q;
  logic enabled;
  logic cmpl;
  logic first_done;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= acs_pkg::CTRL0_RST[acs_pkg::C0_SEL_LSB +: acs_pkg::SEL_W];
      continuous_mode_select_q <= acs_pkg::CTRL0_RST[acs_pkg::C0_CONTINUOUS_MODE_SELECT];
      refout_q <= acs_pkg::CTRL0_RST[acs_pkg::C0_REFOUT];
      refl_q <= acs_pkg::CTRL0_RST[acs_pkg::C0_REFL];
    end
    else if (wr_c0)
    begin
      sel_q <= w_data_q[acs_pkg::C0_SEL_LSB +: acs_pkg::SEL_W];
      continuous_mode_select_q <= w_data_q[acs_pkg::C0_CONTINUOUS_MODE_SELECT];
      refout_q <= w_data_q[acs_pkg::C0_REFOUT];
      refl_q <= w_data_q[acs_pkg::C0_REFL];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      refh_q <= acs_pkg::CTRL1_REFH_RST;
    else if (wr_c1)
      refh_q <= w_data_q[acs_pkg::C1_REFH];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_dis_q <= acs_pkg::PWR_ADC_DIS_RST;
    else if (wr_pwr)
      adc_dis_q <= w_data_q[acs_pkg::PWR_ADC_DIS];
  end

  assign enabled = !adc_dis_q;

  // a software set in the completing cycle wins over the hardware clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_q <= acs_pkg::CTRL0_RST[acs_pkg::C0_START];
    else if (wr_c0 && w_data_q[acs_pkg::C0_START])
      start_q <= 1'b1;
    else if (first_done)
      start_q <= 1'b0;
  end

  // ==========================================================
  // sequencer
  acs_pkg::acs_state_t st_q;
  acs_pkg::acs_state_t st_d;
  logic tmr_load;
  logic [acs_pkg::TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic [acs_pkg::TMR_W-1:0] tmr_cnt;
  logic powered_q;
  logic [7:0] idle_cnt_q;
  logic idle_off;

  always_comb
  begin
    st_d = st_q;
    tmr_load = 1'b0;
    tmr_val = CYC_ZERO();
    cmpl = 1'b0;
    first_done = 1'b0;
    unique case (st_q)
      acs_pkg::S_IDLE:
      begin
        if (start_q && enabled)
        begin
          tmr_load = 1'b1;
          if (powered_q)
          begin
            st_d = acs_pkg::S_FIRST;
            tmr_val = FIRST_LD;
          end
          else
          begin
            st_d = acs_pkg::S_PWRUP;
            tmr_val = acs_pkg::CYC_POWERUP;
          end
        end
      end
      acs_pkg::S_PWRUP:
      begin
        if (!enabled)
          st_d = acs_pkg::S_IDLE;
        else if (tmr_done)
        begin
          st_d = acs_pkg::S_FIRST;
          tmr_load = 1'b1;
          tmr_val = FIRST_LD;
        end
      end
      acs_pkg::S_FIRST:
      begin
        if (!enabled)
          st_d = acs_pkg::S_IDLE;
        else if (tmr_done)
        begin
          cmpl = 1'b1;
          first_done = 1'b1;
          if (continuous_mode_select_q)
          begin
            st_d = acs_pkg::S_CONTINUOUS_MODE_SELECT;
            tmr_load = 1'b1;
            tmr_val = acs_pkg::CYC_REPEAT;
          end
          else
            st_d = acs_pkg::S_IDLE;
        end
      end
      acs_pkg::S_CONTINUOUS_MODE_SELECT:
      begin
        // a cleared mode bit abandons the conversion under way
        if (!enabled || !continuous_mode_select_q)
          st_d = acs_pkg::S_IDLE;
        else if (tmr_done)
        begin
          cmpl = 1'b1;
          tmr_load = 1'b1;
          tmr_val = acs_pkg::CYC_REPEAT;
        end
      end
      default:
        st_d = acs_pkg::S_IDLE;
    endcase
  end

  function automatic logic [acs_pkg::TMR_W-1:0] CYC_ZERO();
    CYC_ZERO = '0;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= acs_pkg::S_IDLE;
    else
      st_q <= st_d;
  end

  acs_seq_timer #(
    .W(acs_pkg::TMR_W)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .clear(st_d == acs_pkg::S_IDLE),
    .done(tmr_done),
    .count(tmr_cnt)
  );

  // ==========================================================
  // power and idle shutdown
  assign idle_off = (st_q == acs_pkg::S_IDLE) && (st_d == acs_pkg::S_IDLE)
    && (idle_cnt_q == acs_pkg::CYC_IDLE_OFF - 8'h01);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_cnt_q <= 8'h00;
    else if (!powered_q || st_q != acs_pkg::S_IDLE || st_d != acs_pkg::S_IDLE || idle_off)
      idle_cnt_q <= 8'h00;
    else
      idle_cnt_q <= idle_cnt_q + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      powered_q <= 1'b0;
    else if (!enabled)
      powered_q <= 1'b0;
    else if (st_d == acs_pkg::S_PWRUP)
      powered_q <= 1'b1;
    else if (idle_off)
      powered_q <= 1'b0;
  end

  // ==========================================================
  // result and interrupt request
  logic [acs_pkg::RES_W-1:0] result_q;
  logic irq_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_q <= '0;
    else if (cmpl)
      result_q <= adc_result;
  end

  // the request is a pulse latched by the interrupt controller, so
  // disabling here can never withdraw one already sent
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= cmpl && enabled;
  end

  assign irq_req = irq_q;
  assign adc_power_on = powered_q;
  assign adc_converting = (st_q == acs_pkg::S_FIRST) || (st_q == acs_pkg::S_CONTINUOUS_MODE_SELECT);
  assign analog_input_select = sel_q;
  assign reference_select = {refh_q, refl_q};
  assign reference_output_enable = refout_q;

  // ==========================================================
  // pin drivers
  logic [N_PINS-1:0] gpio_oe_q;
  logic [N_PINS-1:0] gpio_ie_q;

  generate
    for (genvar i = 0; i < N_PINS; i++)
    begin : g_pin
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          gpio_oe_q[i] <= 1'b0;
          gpio_ie_q[i] <= 1'b1;
        end
        else
        begin
          gpio_oe_q[i] <= gpio_oe_req[i] && !gpio_analog_sel[i];
          gpio_ie_q[i] <= !gpio_analog_sel[i];
        end
      end
    end
  endgenerate

  assign gpio_oe = gpio_oe_q;
  assign gpio_ie = gpio_ie_q;

  // ==========================================================
  // register bus: read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [8:0] cal_hit;

  always_comb
  begin
    cal_hit = cal_read(s_axi_araddr);
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, acs_pkg::OFF_CTRL0))
      rd_mux[7:0] = {start_q, refl_q, refout_q, continuous_mode_select_q, sel_q};
    else if (hit(s_axi_araddr, acs_pkg::OFF_CTRL1))
      rd_mux[acs_pkg::C1_REFH] = refh_q;
    else if (hit(s_axi_araddr, acs_pkg::OFF_DATA_H))
      rd_mux[7:0] = result_q[acs_pkg::RES_W-1 -: acs_pkg::RES_HI_W];
    else if (hit(s_axi_araddr, acs_pkg::OFF_DATA_L))
      rd_mux[7:acs_pkg::RES_LO_LSB] = result_q[acs_pkg::RES_LO_W-1:0];
    else if (hit(s_axi_araddr, acs_pkg::OFF_PWR))
      rd_mux[acs_pkg::PWR_ADC_DIS] = adc_dis_q;
    else if (hit(s_axi_araddr, acs_pkg::OFF_STAT))
    begin
      rd_mux[acs_pkg::ST_BUSY] = (st_q != acs_pkg::S_IDLE);
      rd_mux[acs_pkg::ST_POWERED] = powered_q;
      rd_mux[acs_pkg::ST_CONTINUOUS_MODE_SELECT_RUN] = (st_q == acs_pkg::S_CONTINUOUS_MODE_SELECT);
    end
    else if (cal_hit[8])
      rd_mux[7:0] = cal_hit[7:0];
    else
      rd_ok = 1'b0;
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= acs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // checks
  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn)
    (first_done && !(wr_c0 && w_data_q[acs_pkg::C0_START])) |=> !start_q;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start not cleared");

  property p_idle_off;
    @(posedge aclk) disable iff (!aresetn)
    (powered_q && st_q == acs_pkg::S_IDLE && !start_q && enabled && idle_cnt_q == 8'h9f)
      |=> !powered_q;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("no idle power down");

  property p_result_take;
    @(posedge aclk) disable iff (!aresetn)
    cmpl |=> result_q == $past(adc_result);
  endproperty
  a_result_take: assert property (p_result_take) else $error("result not stored");

  property p_launch_time;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == acs_pkg::S_IDLE && start_q && enabled)
      |=> (powered_q && st_q == acs_pkg::S_FIRST && tmr_cnt == FIRST_LD)
        || (st_q == acs_pkg::S_PWRUP && tmr_cnt == acs_pkg::CYC_POWERUP);
  endproperty
  a_launch_time: assert property (p_launch_time) else $error("bad launch count");

  property p_start_stays;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == acs_pkg::S_CONTINUOUS_MODE_SELECT && !start_q && !wr_c0) |=> !start_q;
  endproperty
  a_start_stays: assert property (p_start_stays) else $error("start set in continuous_mode_select");

  property p_irq_cause;
    @(posedge aclk) disable iff (!aresetn)
    irq_req |-> $past(cmpl) && $past(enabled);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");

  property p_repeat;
    @(posedge aclk) disable iff (!aresetn)
    (cmpl && st_d == acs_pkg::S_CONTINUOUS_MODE_SELECT) |-> ##256 (cmpl || st_q != acs_pkg::S_CONTINUOUS_MODE_SELECT);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat period wrong");

  property p_continuous_mode_select_stop;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == acs_pkg::S_CONTINUOUS_MODE_SELECT && !continuous_mode_select_q) |=> st_q == acs_pkg::S_IDLE && !irq_req;
  endproperty
  a_continuous_mode_select_stop: assert property (p_continuous_mode_select_stop) else $error("continuous_mode_select did not stop");

  property p_disable_off;
    @(posedge aclk) disable iff (!aresetn)
    adc_dis_q |=> !adc_power_on && !adc_converting;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("disabled but powered");

  property p_pin_analog;
    @(posedge aclk) disable iff (!aresetn)
    gpio_analog_sel[0] |=> !gpio_ie[0] && !gpio_oe[0];
  endproperty
  a_pin_analog: assert property (p_pin_analog) else $error("analog pin still digital");
endmodule
`default_nettype wire

// ===== verification/acs_core_model.sv
// behavioural analog core: result carries the input select and the conversion index
`default_nettype none
module acs_core_model (
  input wire logic aclk,
  input wire logic adc_converting,
  input wire logic [acs_pkg::SEL_W-1:0] analog_input_select,
  input wire logic irq_req,
  output logic [acs_pkg::RES_W-1:0] adc_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] idx_q = '0;
  always_ff @(posedge aclk)
  begin
    if (irq_req === 1'b1)
      idx_q <= idx_q + 7'h01;
  end
  // outside a conversion the value is inverted so a late sample cannot pass
  assign adc_result = adc_converting ? {analog_input_select, idx_q}
                                     : ~{analog_input_select, idx_q};
endmodule
`default_nettype wire

// ===== verification/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer with an analog core model
`default_nettype none
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F = 20;
  localparam logic [71:0] CAL = 72'h11_2233_4455_6677_8899;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, analog_input_select, gpio_analog_sel, gpio_oe_req, gpio_oe, gpio_ie;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_select, rr;
  logic [10:0] adc_result, res;
  logic adc_power_on, adc_converting, reference_output_enable, irq_req;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_irq = 0;
  int n;
  real t0;

  acs_top #(.FIRST_CYC(F), .N_PINS(4), .CAL_BYTES(CAL)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_result, .adc_power_on,
    .adc_converting, .analog_input_select, .reference_select, .reference_output_enable,
    .irq_req, .gpio_analog_sel, .gpio_oe_req, .gpio_oe, .gpio_ie);
  acs_core_model core (.aclk, .adc_converting, .analog_input_select, .irq_req, .adc_result);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (irq_req === 1'b1)
      n_irq <= n_irq + 1;

  // =====================================================
  // checking and bus tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    // bready stays up: a following call must not lower and raise it in one step
    if (k >= 50)
    begin
      n_mismatch++;
      report_and_stop();
    end
    check("bresp", s_axi_bresp, er);
    t0 = $realtime;
  endtask
  task automatic rdr(input logic [11:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    if (k >= 50)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // must: a missing pulse ends the run; otherwise n equals lim when none came
  task automatic wirq(input int lim, input bit must);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (irq_req !== 1'b1 && n < lim);
    if (must && irq_req !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic chk_data(input logic [3:0] sel);
    rdr(acs_pkg::OFF_DATA_H);
    // taken after a read, once the interrupt count has settled
    res = {sel, 7'(n_irq - 1)};
    check("data_h", rd, {24'h0, res[10:3]});
    rdr(acs_pkg::OFF_DATA_L);
    check("data_l", rd, {24'h0, res[2:0], 5'h0});
  endtask
  function automatic logic [31:0] lat(input int lo, input int hi);
    int c;
    c = int'(($realtime - t0) / 5.0);
    return 32'((c >= lo) && (c <= hi));
  endfunction

  // =====================================================
  // main sequence
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    gpio_analog_sel = 4'b0101;
    gpio_oe_req = 4'b1111;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // pin registers update at the first edge, so look one edge later
    repeat (2) @(posedge aclk);
    check("gpio_oe", gpio_oe, 4'b1010);
    check("gpio_ie", gpio_ie, 4'b1010);
    rdr(acs_pkg::OFF_CTRL0);
    check("ctrl0", rd, 32'h0);
    rdr(acs_pkg::OFF_STAT);
    check("stat", rd, 32'h0);
    rdr(12'h0fc);
    check("unmapped", {rd[29:0], rr}, 32'h2);
    wr(acs_pkg::OFF_DATA_H, 32'h0000_00ff, 4'hf, acs_pkg::RESP_SLVERR);
    wr(acs_pkg::OFF_CTRL0, 32'h0000_0080, 4'h0, acs_pkg::RESP_OKAY);
    for (int i = 0; i < 9; i++)
    begin
      rdr(acs_pkg::OFF_CAL_BASE + {acs_pkg::CAL_INFO_ADDR[i], 2'b00});
      check("cal", rd, {24'h0, CAL[8*i+:8]});
    end
    rdr(acs_pkg::OFF_CTRL0);
    check("strb0", rd, 32'h0);
    $display("test reset and map done");
    wr(acs_pkg::OFF_CTRL1, 32'h0000_0080, 4'hf, acs_pkg::RESP_OKAY);
    wr(acs_pkg::OFF_CTRL0, 32'h0000_00e5, 4'hf, acs_pkg::RESP_OKAY);
    @(posedge aclk);
    check("sel", analog_input_select, 4'h5);
    check("ref", reference_select, 2'b11);
    check("refout", reference_output_enable, 1'b1);
    rdr(acs_pkg::OFF_CTRL0);
    check("ctrl0", rd, 32'h0000_00e5);
    wirq(F + 80, 1);
    check("latency", lat(F + 40, F + 43), 32'h1);
    chk_data(4'h5);
    rdr(acs_pkg::OFF_CTRL0);
    check("ctrl0", rd, 32'h0000_0065);
    $display("test single done");
    wr(acs_pkg::OFF_CTRL0, 32'h0000_0093, 4'hf, acs_pkg::RESP_OKAY);
    wirq(F + 40, 1);
    check("latency", lat(F, F + 3), 32'h1);
    rdr(acs_pkg::OFF_CTRL0);
    check("ctrl0", rd, 32'h0000_0013);
    rdr(acs_pkg::OFF_STAT);
    check("continuous_mode_select run", rd[2], 1'b1);
    wirq(300, 1);
    wirq(300, 1);
    check("period", n, 256);
    chk_data(4'h3);
    rdr(acs_pkg::OFF_CTRL0);
    check("ctrl0", rd, 32'h0000_0013);
    wr(acs_pkg::OFF_CTRL0, 32'h0000_0003, 4'hf, acs_pkg::RESP_OKAY);
    n = 0;
    while (adc_power_on === 1'b1 && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    check("idle off", lat(157, 164), 32'h1);
    wirq(300, 0);
    check("stopped", n, 300);
    $display("test continuous done");
    wr(acs_pkg::OFF_PWR, 32'h0000_0004, 4'hf, acs_pkg::RESP_OKAY);
    wr(acs_pkg::OFF_CTRL0, 32'h0000_0081, 4'hf, acs_pkg::RESP_OKAY);
    wirq(200, 0);
    check("disabled", n, 200);
    check("power", adc_power_on, 1'b0);
    wr(acs_pkg::OFF_PWR, 32'h0, 4'hf, acs_pkg::RESP_OKAY);
    wirq(F + 80, 1);
    chk_data(4'h1);
    $display("test disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
